// ==== rtl/bps_port.sv ====
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
// Operation
// - Enabled peripheral overrides pin output; reads remain
// - Direction, level, latch, analog, pullup registers
// - Latch write equals pin-level write
// - Latch read latches; level read pins
// - Eight bits; direction 1 input, 0 drive
// - Level write is read-modify-write into latch
// - Direction controls driver even when analog
// - Analog-selected pin reads digital zero
// - Analog select does not affect output
// - Analog select disables input buffer
// - Analog bits reset to analog mode
// - Steering never alters direction; routes overrides
// - Steering bit 1 picks timer clock pin
// - Steering bit 0 picks capture-compare pin
// - Analog bits only pins 5, 3..0
// - Pin six: clock out, oscillator, latch
// - Direction resets to all inputs
module bps_port (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Port pins
	input wire logic [7:0] i_pin,
	output logic [7:0] o_pin,
	output logic [7:0] o_pin_oe_b,
	output logic [7:0] o_pin_ibuf_en,
	output logic [7:0] o_pin_pullup,
	// Peripheral overrides of port pins
	input wire logic [7:0] i_periph_en,
	input wire logic [7:0] i_periph_val,
	input wire bps_pkg::bps_pin6_fn_t i_pin6_fn,
	// Pin steering towards the timer and capture-compare unit
	output bps_pkg::bps_steer_t o_steer,
	// Other ports' pins seen by the steered functions
	input wire logic i_portb_pin_four,
	input wire logic i_portb_pin_five,
	output logic o_timer_external_clock_input,
	input wire logic i_ccp_out_en,
	input wire logic i_ccp_out_val,
	output logic o_portc_pin_one_ovr_en,
	output logic o_porte_pin_seven_ovr_en,
	output logic o_ccp_ovr_val
);

	// =====================================================================
	// Register state
	logic [7:0] direction_q;
	logic [7:0] latch_q;
	logic [7:0] analog_q;
	logic [7:0] steering_q;
	logic [7:0] pullup_q;
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;
	logic [7:0] pin_read;
	logic [7:0] wdata;
	logic [7:0] rdata_d;
	logic wr_en;
	logic setup;
	logic addr_ok;
	logic timer_sel;
	logic ccp_sel;

	// Every register is one byte wide, so only the low byte of the bus is used.
	assign wr_en = i_psel && i_penable && i_pwrite;
	assign setup = i_psel && !i_penable;
	assign wdata = i_pwdata[7:0];

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == bps_pkg::ADDR_PIN_LEVEL) || (a == bps_pkg::ADDR_DIRECTION) ||
			(a == bps_pkg::ADDR_LATCH) || (a == bps_pkg::ADDR_ANALOG) ||
			(a == bps_pkg::ADDR_STEERING) || (a == bps_pkg::ADDR_WEAK_PULLUP);
	endfunction : addr_hit

	// A write lands at the access edge of a transfer aimed at the given address.
	function automatic logic write_hit(input logic en, input logic [7:0] a, input logic [7:0] target);
		write_hit = en && (a == target);
	endfunction : write_hit

	assign addr_ok = addr_hit(i_paddr);
	assign timer_sel = steering_q[bps_pkg::STEER_TMR_BIT];
	assign ccp_sel = steering_q[bps_pkg::STEER_CCP_BIT];

	// =====================================================================
	// Input synchroniser
	// The first stage may settle late, so nothing but the second stage reads it.
	// two-stage synchroniser
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
		end else begin
			sync1_q <= i_pin;
			sync2_q <= sync1_q;
		end
	end

	// Analog pins have their input buffer off, so their sampled level is forced to zero.
	// analog reads zero
	assign pin_read = sync2_q & ~analog_q;

	// =====================================================================
	// Registers
	// Every pin leaves reset as an input, so nothing is driven before software decides.
	// direction reset inputs
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			direction_q <= bps_pkg::DIRECTION_RST;
		end else if (write_hit(wr_en, i_paddr, bps_pkg::ADDR_DIRECTION)) begin
			direction_q <= wdata;
		end
	end

	// A full-byte write through the pin-level address is a read-modify-write
	// whose merge covers every bit, so the stored byte is the written byte; the
	// pin sample is taken at the access edge like a real merge would.
	// latch update path
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			latch_q <= bps_pkg::LATCH_RST;
		end else if (wr_en && (i_paddr == bps_pkg::ADDR_LATCH || i_paddr == bps_pkg::ADDR_PIN_LEVEL)) begin
			latch_q <= (pin_read & 8'h00) | wdata;
		end
	end

	// Unimplemented analog bits are masked on write so that they always read zero.
	// analog select reset
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			analog_q <= bps_pkg::ANALOG_RST;
		end else if (write_hit(wr_en, i_paddr, bps_pkg::ADDR_ANALOG)) begin
			analog_q <= wdata & bps_pkg::ANALOG_MASK;
		end
	end

	// Only the two steering bits are stored; the rest of the byte reads zero.
	// steering reset and mask
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			steering_q <= bps_pkg::STEERING_RST;
		end else if (write_hit(wr_en, i_paddr, bps_pkg::ADDR_STEERING)) begin
			steering_q <= wdata & bps_pkg::STEERING_MASK;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pullup_q <= bps_pkg::PULLUP_RST;
		end else if (write_hit(wr_en, i_paddr, bps_pkg::ADDR_WEAK_PULLUP)) begin
			pullup_q <= wdata;
		end
	end

	// =====================================================================
	// APB read path
	// Unmapped addresses and unimplemented bits read as zero.
	// latch versus pin read
	always_comb begin
		rdata_d = 8'h00;
		case (i_paddr)
			bps_pkg::ADDR_PIN_LEVEL: rdata_d = pin_read;
			bps_pkg::ADDR_DIRECTION: rdata_d = direction_q;
			bps_pkg::ADDR_LATCH: rdata_d = latch_q;
			bps_pkg::ADDR_ANALOG: rdata_d = analog_q;
			bps_pkg::ADDR_STEERING: rdata_d = steering_q;
			bps_pkg::ADDR_WEAK_PULLUP: rdata_d = pullup_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// Ready is raised for the access phase only, so every transfer takes two
	// cycles and a master never waits beyond its first access edge.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pready <= 1'b0;
		end else begin
			o_pready <= setup;
		end
	end

	// An address outside the map is refused with an error beside ready.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pslverr <= 1'b0;
		end else begin
			o_pslverr <= setup && !addr_ok;
		end
	end

	// Read data is captured at the setup edge and stands until the next setup,
	// so a pin-level read returns the level seen one cycle before the access.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_prdata <= '0;
		end else if (setup) begin
			o_prdata <= {24'h00_0000, rdata_d};
		end
	end

	// =====================================================================
	// Pin drive
	logic [7:0] pin_d;
	always_comb begin
		pin_d = latch_q;
		pin_d = (i_periph_en & i_periph_val) | (~i_periph_en & pin_d);
		// Clock output beats oscillator output, which beats the latch and any peripheral.
		// pin six priority
		if (i_pin6_fn.clk_out_en) begin
			pin_d[bps_pkg::PIN_SIX] = i_pin6_fn.clk_out_val;
		end else if (i_pin6_fn.osc_out_en) begin
			pin_d[bps_pkg::PIN_SIX] = i_pin6_fn.osc_out_val;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pin <= bps_pkg::LATCH_RST;
		end else begin
			o_pin <= pin_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pin_oe_b <= bps_pkg::DIRECTION_RST;
		end else begin
			o_pin_oe_b <= direction_q;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pin_ibuf_en <= '0;
		end else begin
			o_pin_ibuf_en <= ~analog_q;
		end
	end

	// A pull-up on a driven pin only wastes current, so it follows the direction bit.
	// pullup on inputs only
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pin_pullup <= bps_pkg::PULLUP_RST;
		end else begin
			o_pin_pullup <= pullup_q & direction_q;
		end
	end

	// =====================================================================
	// Function steering
	// The steering bits are mirrored out so the timer and capture unit see the pin choice.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_steer <= '0;
		end else begin
			o_steer.timer_clk_from_b4 <= timer_sel;
			o_steer.ccp_on_e7 <= ccp_sel;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_timer_external_clock_input <= 1'b0;
		end else begin
			o_timer_external_clock_input <= timer_sel ? i_portb_pin_four : i_portb_pin_five;
		end
	end

	// Only the selected pin gets the override enable; the other pin keeps its own
	// latch and direction, and no direction bit is ever touched from here.
	// route override only
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_portc_pin_one_ovr_en <= 1'b0;
			o_porte_pin_seven_ovr_en <= 1'b0;
			o_ccp_ovr_val <= 1'b0;
		end else begin
			o_portc_pin_one_ovr_en <= i_ccp_out_en && !ccp_sel;
			o_porte_pin_seven_ovr_en <= i_ccp_out_en && ccp_sel;
			o_ccp_ovr_val <= i_ccp_out_val;
		end
	end

endmodule : bps_port

// ==== rtl/bps_pkg.sv ====
package bps_pkg;

	// =====================================================================
	// Register map, byte addresses on APB.
	localparam logic [7:0] ADDR_PIN_LEVEL = 8'h00;
	localparam logic [7:0] ADDR_DIRECTION = 8'h04;
	localparam logic [7:0] ADDR_LATCH = 8'h08;
	localparam logic [7:0] ADDR_ANALOG = 8'h0c;
	localparam logic [7:0] ADDR_STEERING = 8'h10;
	localparam logic [7:0] ADDR_WEAK_PULLUP = 8'h14;

	// =====================================================================
	// Reset values and implemented-bit masks.
	localparam logic [7:0] DIRECTION_RST = 8'hff;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] ANALOG_MASK = 8'h2f;
	localparam logic [7:0] ANALOG_RST = 8'h2f;
	localparam logic [7:0] STEERING_MASK = 8'h03;
	localparam logic [7:0] STEERING_RST = 8'h00;
	localparam logic [7:0] PULLUP_RST = 8'h00;

	// =====================================================================
	// Field positions.
	localparam int STEER_CCP_BIT = 0;
	localparam int STEER_TMR_BIT = 1;
	localparam int PIN_SIX = 6;

	// =====================================================================
	// Grouped signals.
	typedef struct packed {
		logic clk_out_en;
		logic clk_out_val;
		logic osc_out_en;
		logic osc_out_val;
	} bps_pin6_fn_t;

	typedef struct packed {
		logic timer_clk_from_b4;
		logic ccp_on_e7;
	} bps_steer_t;

endpackage : bps_pkg

// ==== verification/bps_port_asserts.sv ====
`timescale 1ns/100ps
// ====
// Port block checker.
module bps_port_chk (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [7:0] o_pin_oe_b,
	input wire logic [7:0] o_pin_ibuf_en,
	input wire logic [7:0] o_pin_pullup,
	input wire bps_pkg::bps_steer_t o_steer,
	input wire logic i_portb_pin_four,
	input wire logic i_portb_pin_five,
	input wire logic o_timer_external_clock_input,
	input wire logic i_ccp_out_en,
	input wire logic o_portc_pin_one_ovr_en,
	input wire logic o_porte_pin_seven_ovr_en
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	logic wr;
	logic [7:0] wd;
	assign wr = i_psel && i_penable && i_pwrite && o_pready;
	assign wd = i_pwdata[7:0];
	chk_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready after setup");
	chk_dir_drive: assert property (wr && i_paddr == bps_pkg::ADDR_DIRECTION |->
		##2 o_pin_oe_b == $past(wd, 2)) else $error("driver enable wrong");
	chk_analog_ibuf: assert property (wr && i_paddr == bps_pkg::ADDR_ANALOG |->
		##2 o_pin_ibuf_en == ~($past(wd, 2) & bps_pkg::ANALOG_MASK)) else $error("input buffer wrong");
	chk_steer_copy: assert property (wr && i_paddr == bps_pkg::ADDR_STEERING |->
		##2 o_steer == 2'($past(wd, 2))) else $error("steering wrong");
	chk_pullup_input: assert property ((o_pin_pullup & ~o_pin_oe_b) == 8'h00)
		else $error("pullup on driven pin");
	chk_timer_route: assert property ($past(i_rst_b) |-> o_timer_external_clock_input ==
		(o_steer.timer_clk_from_b4 ? $past(i_portb_pin_four) : $past(i_portb_pin_five)))
		else $error("timer clock pin wrong");
	chk_ccp_route: assert property ($past(i_rst_b) && $past(i_ccp_out_en) |->
		o_porte_pin_seven_ovr_en == o_steer.ccp_on_e7 && o_portc_pin_one_ovr_en == !o_steer.ccp_on_e7)
		else $error("capture pin wrong");
	chk_unmapped_err: assert property (i_psel && !i_penable && i_paddr > 8'h14 |=>
		o_pslverr && o_prdata == 32'h0) else $error("unmapped not refused");
	cover property (wr && i_paddr == bps_pkg::ADDR_STEERING);
	cover property (o_pslverr);
	cover property (o_porte_pin_seven_ovr_en);
endmodule : bps_port_chk
bind bps_port bps_port_chk i_bps_port_chk (.*);

// ==== verification/bps_pins_model.sv ====
`timescale 1ns/100ps
// ====
// Pads: a driven bit shows the drive, a released bit follows the outside source.
module bps_pins_model (
	input wire logic [7:0] i_drive,
	input wire logic [7:0] i_oe_b,
	input wire logic [7:0] i_ext,
	output logic [7:0] o_level
);
	assign o_level = (i_drive & ~i_oe_b) | (i_ext & i_oe_b);
endmodule : bps_pins_model

// ==== verification/bps_port_tb.sv ====
`timescale 1ns/100ps
`define CK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: %h not %h", $time, a, b); end end
module bps_port_tb;
	logic i_clk, i_rst_b, psel, pen, pwr, rdy, serr, err, b4, b5, cen, cval, tmr, pc1, pe7, cv;
	logic [7:0] addr, lvl, ext, pin, oe_b, ibuf, pull, pen_en, pval;
	logic [31:0] wdata, rdata, r;
	bps_pkg::bps_pin6_fn_t fn6;
	bps_pkg::bps_steer_t steer;
	logic [3:0] p6 [3] = '{4'he, 4'h3, 4'hb};
	logic e6 [3] = '{1'b1, 1'b1, 1'b0};
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	bps_port i_bps_port (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata), .o_pready(rdy), .o_pslverr(serr), .i_pin(lvl),
		.o_pin(pin), .o_pin_oe_b(oe_b), .o_pin_ibuf_en(ibuf), .o_pin_pullup(pull), .i_periph_en(pen_en),
		.i_periph_val(pval), .i_pin6_fn(fn6), .o_steer(steer), .i_portb_pin_four(b4), .i_portb_pin_five(b5),
		.o_timer_external_clock_input(tmr), .i_ccp_out_en(cen), .i_ccp_out_val(cval),
		.o_portc_pin_one_ovr_en(pc1), .o_porte_pin_seven_ovr_en(pe7), .o_ccp_ovr_val(cv));
	bps_pins_model i_bps_pins_model (.i_drive(pin), .i_oe_b(oe_b), .i_ext(ext), .o_level(lvl));
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		addr <= a;
		wdata <= {24'h0, d};
		@(posedge i_clk);
		pen <= 1'b1;
		do @(posedge i_clk); while (rdy !== 1'b1);
		r = rdata;
		err = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		`CK(r, {24'h0, e})
	endtask : rd
	task automatic report_and_stop;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			$display("Error %0t: timeout", $time);
			report_and_stop();
		end
	end
	// ====
	// Sequence of tests.
	initial begin
		{i_rst_b, psel, pen, pwr, addr, wdata, pen_en, pval, fn6, b4, cval} = '0;
		{ext, b5, cen} = {8'h5a, 2'b11};
		repeat (3) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rd(bps_pkg::ADDR_DIRECTION, 8'hff);
		rd(bps_pkg::ADDR_ANALOG, 8'h2f);
		rd(bps_pkg::ADDR_STEERING, 8'h00);
		rd(bps_pkg::ADDR_PIN_LEVEL, 8'h50);
		xfer(1'b1, bps_pkg::ADDR_STEERING, 8'hff);
		rd(bps_pkg::ADDR_STEERING, 8'h03);
		xfer(1'b1, bps_pkg::ADDR_ANALOG, 8'h00);
		xfer(1'b1, bps_pkg::ADDR_DIRECTION, 8'h00);
		xfer(1'b1, bps_pkg::ADDR_LATCH, 8'ha5);
		rd(bps_pkg::ADDR_LATCH, 8'ha5);
		$display("test reset done");
		rd(bps_pkg::ADDR_PIN_LEVEL, 8'ha5);
		`CK(oe_b, 8'h00)
		rd(bps_pkg::ADDR_DIRECTION, 8'h00);
		{b4, b5, cval} <= 3'b101;
		repeat (3) @(posedge i_clk);
		`CK({steer, tmr, pe7, pc1, cv}, 6'b111101)
		xfer(1'b1, bps_pkg::ADDR_STEERING, 8'h00);
		repeat (3) @(posedge i_clk);
		`CK({steer, tmr, pe7, pc1, cv}, 6'b000011)
		`CK(oe_b, 8'h00)
		xfer(1'b1, bps_pkg::ADDR_PIN_LEVEL, 8'h3c);
		rd(bps_pkg::ADDR_LATCH, 8'h3c);
		xfer(1'b1, bps_pkg::ADDR_ANALOG, 8'hff);
		rd(bps_pkg::ADDR_ANALOG, 8'h2f);
		repeat (2) @(posedge i_clk);
		`CK(pin, 8'h3c)
		`CK(ibuf, 8'hd0)
		`CK(oe_b, 8'h00)
		rd(bps_pkg::ADDR_PIN_LEVEL, 8'h10);
		$display("test latch done");
		{pen_en, pval} <= 16'h0101;
		repeat (3) @(posedge i_clk);
		`CK(pin, 8'h3d)
		rd(bps_pkg::ADDR_LATCH, 8'h3c);
		for (int i = 0; i < 3; i++) begin
			fn6 <= p6[i];
			repeat (3) @(posedge i_clk);
			`CK(pin[6], e6[i])
		end
		xfer(1'b1, bps_pkg::ADDR_WEAK_PULLUP, 8'hff);
		xfer(1'b1, bps_pkg::ADDR_DIRECTION, 8'h0f);
		repeat (3) @(posedge i_clk);
		`CK(pull, 8'h0f)
		xfer(1'b0, 8'h18, 8'h00);
		`CK({err, r}, 33'h100000000)
		$display("test override done");
		report_and_stop();
	end
endmodule : bps_port_tb
